//--- rtl/scc_ctrl.v
// Sleep and wake cycle controller with parameter registers and status
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"

module scc_ctrl #(
  parameter MS_CYCLES = `SCC_MS_CYCLES,
  parameter CHECK_MS = 16'd5,
  parameter UNICAST_MS = 16'd20
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Parameter command port
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [3:0] reg_addr_i,
  input wire [23:0] reg_wdata_i,
  output reg [23:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // Network and host events
  input wire host_char_i,
  input wire data_pending_i,
  input wire sync_rx_i,
  input wire sync_missed_i,
  input wire net_sleep_period_valid_i,
  input wire [23:0] net_sleep_period_i,
  input wire [23:0] net_wake_time_i,
  input wire coordinator_i,
  input wire deployment_i,
  input wire commissioning_nominate_request_i,
  input wire msg_queued_i,
  input wire pin_sleep_req_n_i,
  // Sleep and host outputs
  output reg sleep_status_o,
  output reg awake_o,
  output reg host_tx_enable_o,
  output reg msg_discard_o
);

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  localparam ST_AWAKE = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_CHECK = 2'd2;

  reg [15:0] sleep_periods_between_wake_signal;
  reg [23:0] sleep_period;
  reg [23:0] wake_time;
  reg [15:0] wake_host_delay;
  reg [3:0] sleep_mode_select;
  reg [23:0] operational_sleep_period;
  reg [23:0] operational_wake_period;
  reg [15:0] missed_sync_cycles;
  reg [15:0] missed_sync_counter;
  reg ever_sync;
  reg sync_now;
  reg will_nominate;
  reg [1:0] state;
  reg [27:0] ms_cnt;
  reg [15:0] period_cnt;
  reg [3:0] sub10;
  reg [15:0] host_cnt;
  reg [27:0] hold_cnt;
  reg pin_prev;
  wire tick;
  wire cyclic;
  wire sync_mode;
  wire [27:0] sleep_ms;
  wire [27:0] wake_ms;
  wire [7:0] status_word;

  scc_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Clamp a value into its documented range
  function [23:0] scc_clamp;
    input [23:0] v;
    input [23:0] lo;
    input [23:0] hi;
    begin
      if (v < lo) begin
        scc_clamp = lo;
      end else if (v > hi) begin
        scc_clamp = hi;
      end else begin
        scc_clamp = v;
      end
    end
  endfunction

  // Saturating 16-bit increment
  function [15:0] scc_sat_inc;
    input [15:0] v;
    begin
      scc_sat_inc = (v == `SCC_SAT_16) ? v : v + 16'h0001;
    end
  endfunction

  // ---------------------------------------------------------------
  // Derived timing
  // ---------------------------------------------------------------
  assign cyclic = (sleep_mode_select == `SCC_MODE_ASYNC) ||
                  (sleep_mode_select == `SCC_MODE_ASYNC_PIN) ||
                  (sleep_mode_select == `SCC_MODE_SYNC);
  assign sync_mode = (sleep_mode_select == `SCC_MODE_SYNC);
  // Sync mode wakes early by host delay so the host is ready
  assign sleep_ms = (sync_mode && ({4'h0, operational_sleep_period} * 28'd10 >
                    {12'h000, wake_host_delay})) ?
                    {4'h0, operational_sleep_period} * 28'd10 - {12'h000, wake_host_delay} :
                    {4'h0, operational_sleep_period} * 28'd10;
  // Sync mode never wakes shorter than host delay plus a unicast
  assign wake_ms = (sync_mode && ({4'h0, operational_wake_period} <
                   {12'h000, wake_host_delay} + {12'h000, UNICAST_MS})) ?
                   {12'h000, wake_host_delay} + {12'h000, UNICAST_MS} :
                   {4'h0, operational_wake_period};
  // Undocumented bit 7 reads zero
  assign status_word = {1'b0, deployment_i, commissioning_nominate_request_i, will_nominate,
                        sync_now, ever_sync, coordinator_i, awake_o};

  // ---------------------------------------------------------------
  // Register writes and event counters
  // ---------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_periods_between_wake_signal <= `SCC_RST_SPBWS;
      sleep_period <= `SCC_RST_SLEEP_PERIOD;
      wake_time <= `SCC_RST_WAKE_TIME;
      wake_host_delay <= `SCC_RST_WAKE_HOST_DELAY;
      sleep_mode_select <= `SCC_RST_MODE;
      operational_sleep_period <= `SCC_RST_SLEEP_PERIOD;
      operational_wake_period <= `SCC_RST_WAKE_TIME;
      missed_sync_counter <= 16'h0000;
      ever_sync <= 1'b0;
      will_nominate <= 1'b0;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `SCC_REG_SLEEP_PERIODS_BETWEEN_WAKE_SIGNAL: begin
            sleep_periods_between_wake_signal <=
              (reg_wdata_i[15:0] == 16'h0000) ? 16'h0001 : reg_wdata_i[15:0];
            will_nominate <= 1'b1;
          end
          `SCC_REG_SLEEP_PERIOD: begin
            sleep_period <= scc_clamp(reg_wdata_i, 24'h000001, `SCC_MAX_SLEEP_PERIOD);
            will_nominate <= 1'b1;
          end
          `SCC_REG_WAKE_TIME: begin
            wake_time <= scc_clamp(reg_wdata_i, 24'h000001, `SCC_MAX_WAKE_TIME);
            will_nominate <= 1'b1;
          end
          `SCC_REG_WAKE_HOST_DELAY: begin
            wake_host_delay <= reg_wdata_i[15:0];
          end
          `SCC_REG_SLEEP_MODE_SELECT: begin
            sleep_mode_select <= reg_wdata_i[3:0];
          end
          default: begin
          end
        endcase
      end
      // Adopt settings while awake outside cyclic modes; a sync overrides with network values
      if (net_sleep_period_valid_i) begin
        operational_sleep_period <= net_sleep_period_i;
        operational_wake_period <= net_wake_time_i;
      end else if (state == ST_AWAKE && !cyclic) begin
        operational_sleep_period <= sleep_period;
        operational_wake_period <= wake_time;
      end
      if (sync_rx_i) begin
        ever_sync <= 1'b1;
      end
      if (state == ST_AWAKE && tick && ms_cnt == 28'd0 && cyclic) begin
        will_nominate <= 1'b0;
      end
      // Increment wins over a host clear in the same cycle
      if (sync_missed_i) begin
        missed_sync_counter <= scc_sat_inc(missed_sync_counter);
      end else if (reg_wr_i && reg_addr_i == `SCC_REG_MISSED_SYNC_COUNTER &&
                   reg_wdata_i[15:0] == 16'h0000) begin
        missed_sync_counter <= 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sleep and wake sequencer
  // ---------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_AWAKE;
      ms_cnt <= 28'd0;
      sub10 <= 4'h0;
      period_cnt <= 16'h0000;
      awake_o <= 1'b1;
      sleep_status_o <= 1'b1;
      sync_now <= 1'b0;
      missed_sync_cycles <= 16'h0000;
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= pin_sleep_req_n_i;
      if (sync_rx_i) begin
        sync_now <= 1'b1;
        missed_sync_cycles <= 16'h0000;
      end
      case (state)
        ST_AWAKE: begin
          if (!cyclic) begin
            ms_cnt <= 28'd0;
            awake_o <= 1'b1;
            sleep_status_o <= 1'b1;
          end else if (tick) begin
            if (ms_cnt + 28'd1 >= wake_ms) begin
              state <= ST_SLEEP;
              ms_cnt <= 28'd0;
              awake_o <= 1'b0;
              sleep_status_o <= 1'b0;
            end else begin
              ms_cnt <= ms_cnt + 28'd1;
            end
          end
        end
        ST_SLEEP: begin
          if (tick) begin
            if (ms_cnt + 28'd1 >= sleep_ms ||
                (sleep_mode_select == `SCC_MODE_ASYNC_PIN && pin_prev && !pin_sleep_req_n_i)) begin
              ms_cnt <= 28'd0;
              awake_o <= 1'b1;
              if (!sync_rx_i) begin
                sync_now <= 1'b0;
                missed_sync_cycles <= scc_sat_inc(missed_sync_cycles);
              end
              // Count ignored in sync mode
              if (sync_mode || period_cnt + 16'h0001 >= sleep_periods_between_wake_signal) begin
                period_cnt <= 16'h0000;
                sleep_status_o <= 1'b1;
                state <= ST_AWAKE;
              end else begin
                period_cnt <= period_cnt + 16'h0001;
                state <= ST_CHECK;
              end
            end else begin
              ms_cnt <= ms_cnt + 28'd1;
            end
          end
        end
        ST_CHECK: begin
          // Brief data check; full wake only if something arrived
          if (data_pending_i || host_char_i) begin
            sleep_status_o <= 1'b1;
            ms_cnt <= 28'd0;
            state <= ST_AWAKE;
          end else if (tick) begin
            if (ms_cnt + 28'd1 >= {12'h000, CHECK_MS}) begin
              ms_cnt <= 28'd0;
              awake_o <= 1'b0;
              state <= ST_SLEEP;
            end else begin
              ms_cnt <= ms_cnt + 28'd1;
            end
          end
        end
        default: begin
          state <= ST_AWAKE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Host delay and indirect message hold
  // ---------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_cnt <= 16'h0000;
      host_tx_enable_o <= 1'b1;
      hold_cnt <= 28'd0;
      msg_discard_o <= 1'b0;
    end else begin
      msg_discard_o <= 1'b0;
      if (!awake_o) begin
        host_cnt <= wake_host_delay;
        host_tx_enable_o <= 1'b0;
      end else if (host_char_i) begin
        host_cnt <= 16'h0000;
        host_tx_enable_o <= 1'b1;
      end else if (host_cnt == 16'h0000) begin
        host_tx_enable_o <= 1'b1;
      end else if (tick) begin
        host_cnt <= host_cnt - 16'h0001;
      end
      // Hold is 25 ms per sleep unit, i.e. 2.5 times the period
      if (msg_queued_i) begin
        hold_cnt <= {4'h0, operational_sleep_period} * 28'd25;
      end else if (tick && hold_cnt != 28'd0) begin
        hold_cnt <= hold_cnt - 28'd1;
        if (hold_cnt == 28'd1) begin
          msg_discard_o <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 24'h000000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      case (reg_addr_i)
        `SCC_REG_SLEEP_PERIODS_BETWEEN_WAKE_SIGNAL: reg_rdata_o <= {8'h00, sleep_periods_between_wake_signal};
        `SCC_REG_SLEEP_PERIOD: reg_rdata_o <= sleep_period;
        `SCC_REG_WAKE_TIME: reg_rdata_o <= wake_time;
        `SCC_REG_WAKE_HOST_DELAY: reg_rdata_o <= {8'h00, wake_host_delay};
        `SCC_REG_SLEEP_STATUS: reg_rdata_o <= {16'h0000, status_word};
        `SCC_REG_OPERATIONAL_SLEEP_PERIOD: reg_rdata_o <= operational_sleep_period;
        `SCC_REG_OPERATIONAL_WAKE_PERIOD: reg_rdata_o <= operational_wake_period;
        `SCC_REG_MISSED_SYNC_CYCLES: reg_rdata_o <= {8'h00, missed_sync_cycles};
        `SCC_REG_MISSED_SYNC_COUNTER: reg_rdata_o <= {8'h00, missed_sync_counter};
        `SCC_REG_SLEEP_MODE_SELECT: reg_rdata_o <= {20'h00000, sleep_mode_select};
        default: reg_rdata_o <= 24'h000000;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- rtl/scc_defs.vh
// Constants for the sleep cycle controller: register indices, fields, resets, timing
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// ---------------------------------------------------------------
// Register indices on the parameter command port
// ---------------------------------------------------------------
`define SCC_REG_SLEEP_PERIODS_BETWEEN_WAKE_SIGNAL 4'h0
`define SCC_REG_SLEEP_PERIOD 4'h1
`define SCC_REG_WAKE_TIME 4'h2
`define SCC_REG_WAKE_HOST_DELAY 4'h3
`define SCC_REG_SLEEP_STATUS 4'h4
`define SCC_REG_OPERATIONAL_SLEEP_PERIOD 4'h5
`define SCC_REG_OPERATIONAL_WAKE_PERIOD 4'h6
`define SCC_REG_MISSED_SYNC_CYCLES 4'h7
`define SCC_REG_MISSED_SYNC_COUNTER 4'h8
`define SCC_REG_SLEEP_MODE_SELECT 4'h9

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SCC_RST_SPBWS 16'h0001
`define SCC_RST_SLEEP_PERIOD 24'h000190
`define SCC_RST_WAKE_TIME 24'h001F40
`define SCC_RST_WAKE_HOST_DELAY 16'h0000
`define SCC_RST_SLEEP_STATUS 8'h40
`define SCC_RST_MODE 4'h0

// ---------------------------------------------------------------
// Limits
// ---------------------------------------------------------------
`define SCC_MAX_SLEEP_PERIOD 24'h15F900
`define SCC_MAX_WAKE_TIME 24'h36EE80
`define SCC_SAT_16 16'hFFFF

// ---------------------------------------------------------------
// Sleep mode encodings
// ---------------------------------------------------------------
`define SCC_MODE_NORMAL 4'h0
`define SCC_MODE_PIN 4'h1
`define SCC_MODE_ASYNC 4'h4
`define SCC_MODE_ASYNC_PIN 4'h5
`define SCC_MODE_SUPPORT 4'h7
`define SCC_MODE_SYNC 4'h8

// ---------------------------------------------------------------
// Sleep status bit positions
// ---------------------------------------------------------------
`define SCC_SS_NET_AWAKE 0
`define SCC_SS_COORD 1
`define SCC_SS_EVER_SYNC 2
`define SCC_SS_SYNC_NOW 3
`define SCC_SS_WILL_NOMINATE 4
`define SCC_SS_NOM_REQ 5
`define SCC_SS_DEPLOY 6

// ---------------------------------------------------------------
// Timing: clock rate and time base
// ---------------------------------------------------------------
`define SCC_CLK_HZ 40000000
`define SCC_TICK_MS 1
`define SCC_SLEEP_UNIT_MS 10
`define SCC_MS_CYCLES ((`SCC_CLK_HZ / 1000) * `SCC_TICK_MS)

`endif

//--- rtl/scc_tick.v
// Millisecond tick divider for the sleep cycle controller
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"

module scc_tick #(
  parameter CYCLES = `SCC_MS_CYCLES
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Tick out
  output reg tick_o
);

  reg [31:0] cnt;

  // Free running divider, one pulse per millisecond
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (cnt == CYCLES - 1) begin
      cnt <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- verif/scc_ctrl_sva.sv
// Port checker for the sleep cycle controller
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"
module scc_ctrl_chk #(
  parameter MS_CYCLES = 40000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [23:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic host_char_i,
  input wire logic sleep_status_o,
  input wire logic awake_o,
  input wire logic host_tx_enable_o,
  input wire logic msg_discard_o
);
  // Cycles awake so far; a wake never ends before one tick
  logic [31:0] awake_len;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      awake_len <= 32'h00000000;
    else
      awake_len <= awake_o ? awake_len + 32'h00000001 : 32'h00000000;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  chk_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without read");
  chk_status_width: assert property (reg_rvalid_o && $past(reg_addr_i) ==
    `SCC_REG_SLEEP_STATUS |-> reg_rdata_o[23:7] == 17'h00000)
    else $error("status upper bits set");
  chk_count_width: assert property (reg_rvalid_o && $past(reg_addr_i) ==
    `SCC_REG_MISSED_SYNC_COUNTER |-> reg_rdata_o[23:16] == 8'h00)
    else $error("missed count too wide");
  chk_asleep_quiet: assert property (!awake_o |-> !sleep_status_o)
    else $error("status output high while asleep");
  chk_full_hold: assert property ($rose(sleep_status_o) |-> sleep_status_o [*3])
    else $error("full wake too short");
  // Enable is registered off awake_o, so it drops one cycle after sleep entry
  chk_tx_awake: assert property (!awake_o |=> !host_tx_enable_o)
    else $error("host output enabled while asleep");
  chk_char_stops: assert property (host_char_i && awake_o |->
    ##[1:2] (host_tx_enable_o || !awake_o))
    else $error("host char did not stop delay");
  chk_discard_pulse: assert property (msg_discard_o |=> !msg_discard_o)
    else $error("discard longer than one cycle");
  chk_wake_min: assert property ($fell(awake_o) |-> awake_len >= MS_CYCLES - 1)
    else $error("wake shorter than one tick");
  // Main scenarios reached
  cov_full: cover property ($rose(sleep_status_o));
  cov_sleep: cover property ($fell(awake_o));
  cov_char: cover property (host_char_i && awake_o && !host_tx_enable_o);
  cov_discard: cover property (msg_discard_o);
endmodule
bind scc_ctrl scc_ctrl_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .host_char_i(host_char_i), .sleep_status_o(sleep_status_o),
  .awake_o(awake_o), .host_tx_enable_o(host_tx_enable_o), .msg_discard_o(msg_discard_o));
`default_nettype wire

//--- verif/scc_host_model.sv
// Host model on the serial side of the sleep cycle controller
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench requests and read data
  input wire logic send_i,
  input wire logic [23:0] rdata_i,
  // Toward controller and bench
  output logic host_char_o,
  output logic [7:0] status_o
);
  // One character strobe per one-cycle request, launched on the edge; a held request strobes every other cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      host_char_o <= 1'b0;
    else
      host_char_o <= send_i & ~host_char_o;
  end
  // Reserved status bits may hold anything, so drop them
  assign status_o = rdata_i[7:0] & 8'h7F;
endmodule
`default_nettype wire

//--- verif/test_sleep_cycle_controller.sv
// Self-checking bench for the sleep cycle controller
`timescale 1ns/100ps
`default_nettype none
module test_sleep_cycle_controller;
  // ------
  // Stimulus and observed signals
  // ------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, pend = 1'b0, srx = 1'b0, smiss = 1'b0, nval = 1'b0;
  logic coord = 1'b0, deploy = 1'b1, nom = 1'b0, msgq = 1'b0, send = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [23:0] wdata = 24'h000000, nsp = 24'h000003, nwt = 24'h000007, v, rdata;
  logic rvalid, ss, awake, txen, disc, hchar;
  logic [7:0] status;
  logic [23:0] rst_tab [9] = '{24'h000001, 24'h000190, 24'h001F40, 24'h000000,
    24'h000041, 24'h000190, 24'h001F40, 24'h000000, 24'h000000};
  logic [3:0] modes [6] = '{4'h0, 4'h1, 4'h5, 4'h7, 4'h8, 4'h4};
  int errors = 0, checks = 0, n;
  // Short tick so cyclic runs stay brief
  scc_ctrl #(.MS_CYCLES(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .host_char_i(hchar), .data_pending_i(pend), .sync_rx_i(srx),
    .sync_missed_i(smiss), .net_sleep_period_valid_i(nval), .net_sleep_period_i(nsp),
    .net_wake_time_i(nwt), .coordinator_i(coord), .deployment_i(deploy),
    .commissioning_nominate_request_i(nom), .msg_queued_i(msgq), .pin_sleep_req_n_i(1'b1),
    .sleep_status_o(ss), .awake_o(awake), .host_tx_enable_o(txen), .msg_discard_o(disc));
  scc_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .rdata_i(rdata),
    .host_char_o(hchar), .status_o(status));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // ------
  // Tasks
  // ------
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [23:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    step;
    wr = 1'b0;
    step;
  endtask
  // Read answer arrives a cycle later; address held meanwhile
  task automatic reg_rd(input logic [3:0] a, output logic [23:0] d);
    int k = 0;
    rd = 1'b1;
    addr = a;
    step;
    rd = 1'b0;
    while (rvalid !== 1'b1 && k < 4) begin
      step;
      k++;
    end
    if (k == 4)
      chk_bit("rvalid", 1'b1, rvalid);
    d = rdata;
    step;
  endtask
  task automatic wrd(input logic [3:0] a, input logic [23:0] d, input logic [23:0] e);
    reg_wr(a, d);
    reg_rd(a, v);
    chk_val($sformatf("reg%0h", a), e, v);
  endtask
  // Bounded wait on awake, host enable, status output or discard
  task automatic wait_sig(input int s, input logic lv, output int c);
    c = 0;
    while ((s == 0 ? awake : s == 1 ? txen : s == 2 ? ss : disc) !== lv && c < 400) begin
      step;
      c++;
    end
    if (c == 400)
      chk_bit($sformatf("sig%0d", s), lv, ~lv);
  endtask
  task automatic next_full;
    int c;
    for (int k = 0; k < 3; k++) begin
      wait_sig(0, 1'b0, c);
      wait_sig(0, 1'b1, c);
      if (ss === 1'b1)
        break;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    #2400000;
    errors++;
    wrap_up;
  end
  // ------
  // Tests
  // ------
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    step;
    for (int i = 0; i < 9; i++) begin
      reg_rd(i[3:0], v);
      chk_val("reset", rst_tab[i], i == 4 ? {16'h0000, status} : v);
    end
    wrd(4'h1, 24'h000000, 24'h000001);
    wrd(4'h1, 24'h15F901, 24'h15F900);
    wrd(4'h2, 24'h000000, 24'h000001);
    wrd(4'h2, 24'h36EE81, 24'h36EE80);
    wrd(4'h0, 24'h000000, 24'h000001);
    wrd(4'h5, 24'h000123, 24'h15F900);
    wrd(4'h6, 24'h000123, 24'h36EE80);
    wrd(4'h3, 24'h00FFFF, 24'h00FFFF);
    reg_wr(4'hF, 24'h000001);
    wrd(4'h1, 24'h000001, 24'h000001);
    wrd(4'h2, 24'h000003, 24'h000003);
    wrd(4'h0, 24'h000002, 24'h000002);
    wrd(4'h3, 24'h000000, 24'h000000);
    $display("test registers done");
    coord = 1'b1;
    nom = 1'b1;
    srx = 1'b1;
    step;
    srx = 1'b0;
    reg_rd(4'h4, v);
    chk_val("status", 24'h00007F, {16'h0000, status});
    msgq = 1'b1;
    step;
    msgq = 1'b0;
    wait_sig(3, 1'b1, n);
    chk_rng("hold", 94, 106, n);
    coord = 1'b0;
    for (int i = 0; i < 3; i++) begin
      smiss = 1'b1;
      step;
      smiss = 1'b0;
      step;
    end
    reg_rd(4'h8, v);
    chk_val("missed", 24'h000003, v);
    wrd(4'h8, 24'h000007, 24'h000003);
    wrd(4'h8, 24'h000000, 24'h000000);
    smiss = 1'b1;
    repeat (65540) step;
    smiss = 1'b0;
    reg_rd(4'h8, v);
    chk_val("saturate", 24'h00FFFF, v);
    $display("test status done");
    foreach (modes[i]) wrd(4'h9, {20'h00000, modes[i]}, {20'h00000, modes[i]});
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    chk_rng("sleep", 36, 48, n);
    chk_bit("check", 1'b0, ss);
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    chk_bit("full", 1'b1, ss);
    pend = 1'b1;
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    wait_sig(2, 1'b1, n);
    chk_rng("pending", 0, 24, n);
    pend = 1'b0;
    reg_wr(4'h3, 24'h000002);
    reg_wr(4'h2, 24'h000006);
    next_full;
    chk_bit("txen", 1'b0, txen);
    wait_sig(1, 1'b1, n);
    chk_rng("delay", 5, 12, n);
    next_full;
    send = 1'b1;
    step;
    send = 1'b0;
    wait_sig(1, 1'b1, n);
    chk_rng("stop", 0, 3, n);
    $display("test async done");
    // Operational values only follow settings outside cyclic modes
    reg_wr(4'h9, 24'h000000);
    reg_wr(4'h3, 24'h000005);
    reg_wr(4'h1, 24'h000002);
    reg_wr(4'h2, 24'h000001);
    reg_wr(4'h9, 24'h000008);
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    chk_rng("sync sleep", 56, 68, n);
    chk_bit("sync full", 1'b1, ss);
    wait_sig(0, 1'b0, n);
    chk_rng("sync wake", 96, 399, n);
    wait_sig(0, 1'b1, n);
    chk_bit("sync full", 1'b1, ss);
    nval = 1'b1;
    step;
    nval = 1'b0;
    reg_rd(4'h5, v);
    chk_val("op sleep", 24'h000003, v);
    reg_rd(4'h6, v);
    chk_val("op wake", 24'h000007, v);
    $display("test sync done");
    wrap_up;
  end
endmodule
`default_nettype wire
